// ---- include/shpbf_pkg.sv ----
// shared constants for the serial host port and bitstream fifo flow control
package shpbf_pkg;

	// host register byte offsets; the link carries offset bits [6:1]
	localparam logic [6:0] SHPBF_OFF_CHIP_ID   = 7'h38;
	localparam logic [6:0] SHPBF_OFF_FIFO_WR   = 7'h60;
	localparam logic [6:0] SHPBF_OFF_FIFO_STAT = 7'h62;
	localparam logic [6:0] SHPBF_OFF_FIFO_CFG  = 7'h64;

	localparam int SHPBF_ADDR_W = 6;
	localparam int SHPBF_DATA_W = 16;
	localparam int SHPBF_CNT_W  = 5;
	localparam int SHPBF_FREE_W = 8;
	localparam int SHPBF_THR_W  = 4;

	localparam logic [SHPBF_ADDR_W-1:0] SHPBF_IDX_CHIP_ID   = SHPBF_OFF_CHIP_ID[6:1];
	localparam logic [SHPBF_ADDR_W-1:0] SHPBF_IDX_FIFO_WR   = SHPBF_OFF_FIFO_WR[6:1];
	localparam logic [SHPBF_ADDR_W-1:0] SHPBF_IDX_FIFO_STAT = SHPBF_OFF_FIFO_STAT[6:1];
	localparam logic [SHPBF_ADDR_W-1:0] SHPBF_IDX_FIFO_CFG  = SHPBF_OFF_FIFO_CFG[6:1];

	// frame layout: direction, six address bits, one ignored bit, sixteen data bits
	localparam logic [SHPBF_CNT_W-1:0] SHPBF_FRAME_BITS = 5'h18;
	localparam logic [SHPBF_CNT_W-1:0] SHPBF_HDR_BITS   = 5'h08;
	localparam logic [SHPBF_CNT_W-1:0] SHPBF_LAST_BIT   = 5'h17;
	localparam logic                   SHPBF_DIR_READ   = 1'b1;

	// fifo configuration word layout
	localparam int SHPBF_CFG_SWAP_BIT = 6;
	localparam int SHPBF_CFG_FLOW_BIT = 5;
	localparam int SHPBF_CFG_THR_LSB  = 0;
	localparam logic [SHPBF_DATA_W-1:0] SHPBF_CFG_WR_MASK = 16'h006f;
	localparam logic [SHPBF_DATA_W-1:0] SHPBF_CFG_RESET   = 16'h0000;

	// fifo status word layout
	localparam int SHPBF_STAT_SPACE_BIT = 0;

	// arbitrary neutral identification value
	localparam logic [SHPBF_DATA_W-1:0] SHPBF_CHIP_ID_DEFAULT = 16'h5a11;

endpackage

// ---- testbench/shpbf_host_model.sv ----
// serial master standing in for the host processor
`timescale 1ns/100ps
module shpbf_host_model (
	output logic      serial_clock_in,
	output logic      serial_select_n,
	output logic      serial_data_in,
	input  wire logic serial_data_out
);
	initial begin
		// after all processes wait, so the select edge clears the link counters
		serial_clock_in <= 1'b1;
		serial_select_n <= 1'b1;
		serial_data_in  <= 1'b0;
	end
	// n below 24 cuts the frame short; clock only runs inside frames
	task automatic xfer(input logic rd, input logic [5:0] idx, input logic [15:0] wd,
		input int n, output logic [15:0] rdat);
		logic [23:0] sh;
		sh   = {rd, idx, 1'b0, wd};
		rdat = 16'h0000;
		serial_select_n = 1'b0;
		#20;
		for (int i = 0; i < n; i++) begin
			serial_clock_in = 1'b0;
			serial_data_in  = sh[23-i];
			#16;
			serial_clock_in = 1'b1;
			if (i >= 8)
				rdat = {rdat[14:0], serial_data_out};
			#16;
		end
		#20;
		serial_select_n = 1'b1;
		serial_data_in  = ~serial_data_in;
		// deselect gap, so back-to-back frames never merge into one
		#40;
	endtask
endmodule

// ---- testbench/shpbf_port_checker.sv ----
// pin-level assertions for the serial host port
`timescale 1ns/100ps
module shpbf_port_checker
	import shpbf_pkg::*;
(
	input wire logic                    core_clk,
	input wire logic                    rst_n,
	input wire logic                    serial_clock_in,
	input wire logic                    serial_select_n,
	input wire logic                    serial_data_in,
	input wire logic                    serial_data_out,
	input wire logic                    serial_output_enable,
	input wire logic [SHPBF_FREE_W-1:0] fifo_free_count,
	input wire logic                    fifo_wr_valid,
	input wire logic [SHPBF_DATA_W-1:0] fifo_wr_data,
	input wire logic                    serial_dma_request,
	input wire logic                    host_stall_n,
	input wire logic                    fifo_space_status
);
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic       rd_reg;
	logic       rd_next;
	always_comb begin
		cnt_next = (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
		rd_next  = (cnt_reg == 5'h00) ? serial_data_in : rd_reg;
	end
	// cleared by select at once, as the frame logic it shadows
	always_ff @(posedge serial_clock_in or posedge serial_select_n) begin
		if (serial_select_n) begin
			cnt_reg <= 5'h00;
			rd_reg  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			rd_reg  <= rd_next;
		end
	end
	property p_oe_off; @(posedge serial_clock_in) disable iff (!rst_n || serial_select_n)
		(cnt_reg < 5'h08 || !rd_reg) |-> !serial_output_enable; endproperty
	a_oe_off: assert property (p_oe_off) else $error("enable outside read data");
	property p_oe_on; @(posedge serial_clock_in) disable iff (!rst_n || serial_select_n)
		rd_reg && cnt_reg >= 5'h08 && cnt_reg < 5'h18 |-> serial_output_enable; endproperty
	a_oe_on: assert property (p_oe_on) else $error("enable missing in read data");
	property p_idle; @(posedge core_clk) disable iff (!rst_n)
		serial_select_n && $past(serial_select_n) |-> !serial_output_enable && !serial_data_out;
	endproperty
	a_idle: assert property (p_idle) else $error("output active while deselected");
	property p_full; @(posedge core_clk) disable iff (!rst_n)
		fifo_free_count >= 8'h0f |=> fifo_space_status; endproperty
	a_full: assert property (p_full) else $error("space status low with room");
	property p_nodma; @(posedge core_clk) disable iff (!rst_n)
		!fifo_space_status |-> !serial_dma_request; endproperty
	a_nodma: assert property (p_nodma) else $error("dma request without space");
	property p_excl; @(posedge core_clk) disable iff (!rst_n)
		serial_dma_request |-> host_stall_n && fifo_space_status; endproperty
	a_excl: assert property (p_excl) else $error("dma request with stall");
	property p_pulse; @(posedge core_clk) disable iff (!rst_n)
		fifo_wr_valid |=> !fifo_wr_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse too long");
	property p_hold; @(posedge core_clk) disable iff (!rst_n)
		$changed(fifo_wr_data) |-> fifo_wr_valid; endproperty
	a_hold: assert property (p_hold) else $error("write data moved without pulse");
	c_wr: cover property (@(posedge core_clk) fifo_wr_valid);
	c_stall: cover property (@(posedge core_clk) !host_stall_n);
	c_rd: cover property (@(posedge serial_clock_in) serial_output_enable);
endmodule
bind shpbf_port shpbf_port_checker i_chk (.core_clk(core_clk), .rst_n(rst_n),
	.serial_clock_in(serial_clock_in), .serial_select_n(serial_select_n),
	.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
	.serial_output_enable(serial_output_enable), .fifo_free_count(fifo_free_count),
	.fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data),
	.serial_dma_request(serial_dma_request), .host_stall_n(host_stall_n),
	.fifo_space_status(fifo_space_status));

// ---- testbench/testbench.sv ----
// self-checking bench for the serial host port
`timescale 1ns/100ps
module testbench;
	import shpbf_pkg::*;
	localparam logic [15:0] ID_WORD = 16'h2c7e; // arbitrary value
	logic        core_clk = 1'b0;
	logic        rst_n;
	logic [7:0]  free     = 8'h20;
	logic        sclk, sel_n, sdi, sdo, soe, wr_valid, dma, stall_n, space;
	logic [15:0] wr_data;
	logic [15:0] rd;
	int          bad_count   = 0;
	int          checks_done = 0;
	always #50 core_clk = ~core_clk;
	shpbf_port #(.CHIP_ID_WORD(ID_WORD)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
		.serial_clock_in(sclk), .serial_select_n(sel_n), .serial_data_in(sdi),
		.serial_data_out(sdo), .serial_output_enable(soe), .fifo_free_count(free),
		.fifo_wr_valid(wr_valid), .fifo_wr_data(wr_data), .serial_dma_request(dma),
		.host_stall_n(stall_n), .fifo_space_status(space));
	shpbf_host_model i_host (.serial_clock_in(sclk), .serial_select_n(sel_n),
		.serial_data_in(sdi), .serial_data_out(sdo));
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// settle time lets the write cross into the core before the next frame
	task automatic wr(input logic [6:0] off, input logic [15:0] d, input int n);
		i_host.xfer(1'b0, off[6:1], d, n, rd);
		repeat (6) @(posedge core_clk);
	endtask
	task automatic rdchk(input string name, input logic [6:0] off, input logic [15:0] exp);
		i_host.xfer(1'b1, off[6:1], 16'h0000, 24, rd);
		chk(name, rd, exp);
	endtask
	task automatic flow(input logic [7:0] f, input logic [2:0] exp);
		@(posedge core_clk);
		free <= f;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("flow", {13'h0, dma, stall_n, space}, {13'h0, exp});
	endtask
	task automatic wr_fifo(input logic [15:0] d, input int n, input logic [15:0] exp,
		input int pulses);
		int seen;
		seen = 0;
		i_host.xfer(1'b0, SHPBF_IDX_FIFO_WR, d, n, rd);
		repeat (10) begin
			@(negedge core_clk);
			if (wr_valid === 1'b1)
				seen++;
		end
		chk("wr_pulses", seen[15:0], pulses[15:0]);
		chk("wr_data", wr_data, exp);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		stop_test();
	end
	initial begin
		// a real edge at time 0, so the link's asynchronous clear is seen
		rst_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		flow(8'h20, 3'b111);
		wr(SHPBF_OFF_FIFO_CFG, 16'h0045, 24);
		rdchk("cfg", SHPBF_OFF_FIFO_CFG, 16'h0045);
		rdchk("id", SHPBF_OFF_CHIP_ID, ID_WORD);
		wr(SHPBF_OFF_CHIP_ID, 16'h0000, 24);
		rdchk("id_ro", SHPBF_OFF_CHIP_ID, ID_WORD);
		flow(8'h04, 3'b010);
		rdchk("stat0", SHPBF_OFF_FIFO_STAT, 16'h0000);
		flow(8'h05, 3'b111);
		rdchk("stat1", SHPBF_OFF_FIFO_STAT, 16'h0001);
		wr_fifo(16'h1234, 24, 16'h3412, 1);
		wr_fifo(16'h5678, 20, 16'h3412, 0);
		wr(SHPBF_OFF_FIFO_CFG, 16'h0025, 24);
		flow(8'h04, 3'b000);
		flow(8'h05, 3'b011);
		wr_fifo(16'habcd, 24, 16'habcd, 1);
		wr(SHPBF_OFF_FIFO_CFG, 16'h0000, 12);
		rdchk("cfg_keep", SHPBF_OFF_FIFO_CFG, 16'h0025);
		rdchk("fifo_rd", SHPBF_OFF_FIFO_WR, 16'h0000);
		stop_test();
	end
endmodule

// ---- verilog/shpbf_link.sv ----
// serial link shifter running on the host's serial clock
`timescale 1ns/100ps
module shpbf_link
	import shpbf_pkg::*;
(
	input  wire logic                        rst_n,
	input  wire logic                        serial_clock_in,
	input  wire logic                        serial_select_n,
	input  wire logic                        serial_data_in,
	output logic                             serial_data_out,
	output logic                             serial_output_enable,
	input  wire logic [SHPBF_DATA_W-1:0]     rd_chip_id,
	input  wire logic [SHPBF_DATA_W-1:0]     rd_cfg,
	input  wire logic                        rd_space_ok,
	output logic                             wr_toggle,
	output logic [SHPBF_ADDR_W-1:0]          wr_addr,
	output logic [SHPBF_DATA_W-1:0]          wr_data
);
	import shpbf_pkg::*;

	logic [SHPBF_CNT_W-1:0]  bit_cnt_reg, bit_cnt_next;
	logic [22:0]             shift_in_reg, shift_in_next;
	logic                    space_meta_reg, space_sync_reg;
	logic                    wr_toggle_reg, wr_toggle_next;
	logic [SHPBF_ADDR_W-1:0] wr_addr_reg, wr_addr_next;
	logic [SHPBF_DATA_W-1:0] wr_data_reg, wr_data_next;
	logic [SHPBF_DATA_W-1:0] out_shift_reg, out_shift_next;
	logic                    out_en_reg, out_en_next;
	logic [SHPBF_DATA_W-1:0] rd_word;
	logic                    frame_write;

	// capture side: rising edges, cleared whenever select is high
	always_comb begin
		bit_cnt_next = bit_cnt_reg;
		if (bit_cnt_reg != SHPBF_FRAME_BITS) begin
			bit_cnt_next = bit_cnt_reg + 5'h01;
		end
		shift_in_next = {shift_in_reg[21:0], serial_data_in};
	end

	always_ff @(posedge serial_clock_in or posedge serial_select_n) begin
		if (serial_select_n) begin
			bit_cnt_reg  <= '0;
			shift_in_reg <= '0;
		end else begin
			bit_cnt_reg  <= bit_cnt_next;
			shift_in_reg <= shift_in_next;
		end
	end

	// a write commits only on the 24th rising edge, so short frames never reach the core
	assign frame_write = (bit_cnt_reg == SHPBF_LAST_BIT) && (shift_in_reg[22] != SHPBF_DIR_READ);

	always_comb begin
		wr_toggle_next = wr_toggle_reg;
		wr_addr_next   = wr_addr_reg;
		wr_data_next   = wr_data_reg;
		if (frame_write) begin
			wr_toggle_next = ~wr_toggle_reg;
			wr_addr_next   = shift_in_reg[21:16];
			wr_data_next   = {shift_in_reg[14:0], serial_data_in};
		end
	end

	// the link clock stops between frames, so the core reset clears these directly
	always_ff @(posedge serial_clock_in or negedge rst_n) begin
		if (!rst_n) begin
			wr_toggle_reg  <= 1'b0;
			wr_addr_reg    <= '0;
			wr_data_reg    <= '0;
			space_meta_reg <= 1'b0;
			space_sync_reg <= 1'b0;
		end else begin
			wr_toggle_reg  <= wr_toggle_next;
			wr_addr_reg    <= wr_addr_next;
			wr_data_reg    <= wr_data_next;
			space_meta_reg <= rd_space_ok;
			space_sync_reg <= space_meta_reg;
		end
	end

	// the configuration word only changes after a completed write frame, so it is
	// quasi-static while a later read frame samples it
	always_comb begin
		rd_word = '0;
		unique case (shift_in_reg[6:1])
			SHPBF_IDX_CHIP_ID:   rd_word = rd_chip_id;
			SHPBF_IDX_FIFO_CFG:  rd_word = rd_cfg;
			SHPBF_IDX_FIFO_STAT: rd_word[SHPBF_STAT_SPACE_BIT] = space_sync_reg;
			default:             rd_word = '0;
		endcase
	end

	// launch side: falling edges
	always_comb begin
		out_shift_next = out_shift_reg;
		out_en_next    = out_en_reg;
		if (bit_cnt_reg == SHPBF_HDR_BITS && shift_in_reg[7] == SHPBF_DIR_READ) begin
			out_shift_next = rd_word;
			out_en_next    = 1'b1;
		end else if (out_en_reg) begin
			out_shift_next = {out_shift_reg[14:0], 1'b0};
		end
	end

	always_ff @(negedge serial_clock_in or posedge serial_select_n) begin
		if (serial_select_n) begin
			out_shift_reg <= '0;
			out_en_reg    <= 1'b0;
		end else begin
			out_shift_reg <= out_shift_next;
			out_en_reg    <= out_en_next;
		end
	end

	assign serial_data_out      = out_shift_reg[SHPBF_DATA_W-1];
	assign serial_output_enable = out_en_reg;
	assign wr_toggle            = wr_toggle_reg;
	assign wr_addr              = wr_addr_reg;
	assign wr_data              = wr_data_reg;

endmodule

// ---- verilog/shpbf_port.sv ----
// serial host port top: register file, write crossing and fifo flow control
`timescale 1ns/100ps
// register map on the link, by byte offset:
//   0x38 identification, read only, writes dropped
//   0x60 bitstream word toward memory, reads return zero
//   0x62 space status in bit 0, read only
//   0x64 configuration: bit 6 byte swap, bit 5 flow select, bits 3:0 threshold
// the link carries offset bits 6 to 1; bit 0 is always zero
// any other offset reads zero and ignores writes

module shpbf_port
	import shpbf_pkg::*;
#(
	parameter logic [SHPBF_DATA_W-1:0] CHIP_ID_WORD = SHPBF_CHIP_ID_DEFAULT
)
(
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic                        serial_clock_in,
	input  wire logic                        serial_select_n,
	input  wire logic                        serial_data_in,
	output logic                             serial_data_out,
	output logic                             serial_output_enable,
	input  wire logic [SHPBF_FREE_W-1:0]     fifo_free_count,
	output logic                             fifo_wr_valid,
	output logic [SHPBF_DATA_W-1:0]          fifo_wr_data,
	output logic                             serial_dma_request,
	output logic                             host_stall_n,
	output logic                             fifo_space_status
);
	import shpbf_pkg::*;

	logic                    link_toggle;
	logic [SHPBF_ADDR_W-1:0] link_addr;
	logic [SHPBF_DATA_W-1:0] link_data;

	logic                    tog_meta_reg, tog_sync_reg, tog_seen_reg;
	logic                    tog_meta_next, tog_sync_next, tog_seen_next;
	logic                    wr_event;
	logic                    cfg_wr_hit;
	logic                    fifo_wr_hit;

	logic [SHPBF_DATA_W-1:0] cfg_reg, cfg_next;
	logic                    swap_sel;
	logic                    flow_sel;
	logic [SHPBF_THR_W-1:0]  space_threshold;
	logic [SHPBF_FREE_W-1:0] free_threshold;

	logic                    fifo_wr_valid_reg, fifo_wr_valid_next;
	logic [SHPBF_DATA_W-1:0] fifo_wr_data_reg, fifo_wr_data_next;

	logic                    space_ok_reg, space_ok_next;
	logic                    dma_req_reg, dma_req_next;
	logic                    stall_n_reg, stall_n_next;

	// swapping is pure wiring and costs no cycle
	function automatic logic [SHPBF_DATA_W-1:0] swap_bytes(input logic [SHPBF_DATA_W-1:0] w);
		swap_bytes = {w[7:0], w[15:8]};
	endfunction

	// everything clocked by the host's serial clock lives in the link module
	// read words are answered inside the link from quasi-static core state
	shpbf_link u_link (
		.rst_n                (rst_n),
		.serial_clock_in      (serial_clock_in),
		.serial_select_n      (serial_select_n),
		.serial_data_in       (serial_data_in),
		.serial_data_out      (serial_data_out),
		.serial_output_enable (serial_output_enable),
		.rd_chip_id           (CHIP_ID_WORD),
		.rd_cfg               (cfg_reg),
		.rd_space_ok          (space_ok_reg),
		.wr_toggle            (link_toggle),
		.wr_addr              (link_addr),
		.wr_data              (link_data)
	);

	// write events cross as a toggle; address and data stay still until the next
	// write frame ends, which is far longer than the three-flop crossing
	// one core cycle pulse per completed write frame
	assign wr_event = tog_sync_reg ^ tog_seen_reg;

	always_comb begin
		tog_meta_next = link_toggle;
		tog_sync_next = tog_meta_reg;
		tog_seen_next = tog_sync_reg;
	end

	// two flops resolve the crossing, the third remembers the last level seen
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tog_meta_reg <= 1'b0;
			tog_sync_reg <= 1'b0;
			tog_seen_reg <= 1'b0;
		end else begin
			tog_meta_reg <= tog_meta_next;
			tog_sync_reg <= tog_sync_next;
			tog_seen_reg <= tog_seen_next;
		end
	end

	// write decode; only the fifo port and the configuration have a write path
	always_comb begin
		cfg_wr_hit  = 1'b0;
		fifo_wr_hit = 1'b0;
		if (wr_event) begin
			unique case (link_addr)
				SHPBF_IDX_FIFO_CFG:  cfg_wr_hit  = 1'b1;
				SHPBF_IDX_FIFO_WR:   fifo_wr_hit = 1'b1;
				// status and identification are read only; their writes are dropped
				SHPBF_IDX_CHIP_ID:   cfg_wr_hit  = 1'b0;
				SHPBF_IDX_FIFO_STAT: cfg_wr_hit  = 1'b0;
				default:             cfg_wr_hit  = 1'b0;
			endcase
		end
	end

	// configuration register
	assign swap_sel        = cfg_reg[SHPBF_CFG_SWAP_BIT];
	assign flow_sel        = cfg_reg[SHPBF_CFG_FLOW_BIT];
	assign space_threshold = cfg_reg[SHPBF_CFG_THR_LSB +: SHPBF_THR_W];
	assign free_threshold  = {{(SHPBF_FREE_W-SHPBF_THR_W){1'b0}}, space_threshold};

	always_comb begin
		cfg_next = cfg_reg;
		if (cfg_wr_hit) begin
			// reserved bits are kept at zero even if the host writes ones
			cfg_next = link_data & SHPBF_CFG_WR_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// threshold zero after reset: space reads as available until software sets one
			cfg_reg <= SHPBF_CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// bitstream words toward memory; writes to the identification offset are dropped
	// a cut frame never flips the toggle, so no word reaches memory from it
	always_comb begin
		fifo_wr_valid_next = 1'b0;
		fifo_wr_data_next  = fifo_wr_data_reg;
		if (fifo_wr_hit) begin
			fifo_wr_valid_next = 1'b1;
			if (swap_sel) begin
				fifo_wr_data_next = swap_bytes(link_data);
			end else begin
				fifo_wr_data_next = link_data;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fifo_wr_valid_reg <= 1'b0;
			fifo_wr_data_reg  <= '0;
		end else begin
			fifo_wr_valid_reg <= fifo_wr_valid_next;
			fifo_wr_data_reg  <= fifo_wr_data_next;
		end
	end

	// flow control; the free count comes from fifo logic on this same clock
	always_comb begin
		space_ok_next = (fifo_free_count >= free_threshold);
		if (flow_sel) begin
			// stall mode: the request stays low and wait carries the back-pressure
			dma_req_next = 1'b0;
			stall_n_next = space_ok_next;
		end else begin
			// request mode: wait never pulls, the request follows the space flag
			dma_req_next = space_ok_next;
			stall_n_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// request low and wait released, so the host sees no stale back-pressure
			space_ok_reg <= 1'b0;
			dma_req_reg  <= 1'b0;
			stall_n_reg  <= 1'b1;
		end else begin
			space_ok_reg <= space_ok_next;
			dma_req_reg  <= dma_req_next;
			stall_n_reg  <= stall_n_next;
		end
	end

	// data and level outputs all come straight from flops
	assign fifo_wr_valid      = fifo_wr_valid_reg;
	assign fifo_wr_data       = fifo_wr_data_reg;
	assign serial_dma_request = dma_req_reg;
	assign host_stall_n       = stall_n_reg;
	assign fifo_space_status  = space_ok_reg;

endmodule
